// >>> core/cpmc_top.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module cpmc_top (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Saved configuration restore.
  input wire logic RESTORE,
  input wire logic [39:0] RESTORE_CFG,
  // AXI4-Lite write address.
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data.
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response.
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read.
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Clock path controls.
  output logic PLL_PWR_DOWN,
  output logic VCO_PWR_ON,
  output logic SRC_VCO,
  output logic DIV_BYPASS,
  output logic [2:0] DIV_RATIO,
  output logic POL_NEG,
  output logic [2:0] REF_EN,
  output logic CAL_START,
  output logic CAL_BUSY
);

  // -----------------------------------------------------------------
  // Register storage.
  // -----------------------------------------------------------------
  logic [7:0] stg_q [5];
  logic [7:0] act_q [5];
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic wstrb_q;
  logic restore_s1_q;
  logic restore_s2_q;
  logic restore_s3_q;
  logic restore_q;
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic rresp_q;
  logic cal_prev_q;
  logic [3:0] cal_cnt_q;
  logic wr_go;
  logic wr_hit;
  logic upd;
  logic rd_go;
  logic rd_hit;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  // Maps a byte address to a staged register slot; 5 means update, 7 miss.
  // Unaligned byte addresses never match a register.
  function automatic logic [2:0] decode(input logic [11:0] a);
    logic [11:0] idx;
    idx = {2'h0, a[11:2]};
    if (a[1:0] != 2'h0) begin
      decode = 3'h7;
    end else begin
      unique case (idx)
        cpmc_pkg::CPMC_IDX_PWR: decode = 3'h0;
        cpmc_pkg::CPMC_IDX_CAL: decode = 3'h1;
        cpmc_pkg::CPMC_IDX_REF: decode = 3'h2;
        cpmc_pkg::CPMC_IDX_DIV: decode = 3'h3;
        cpmc_pkg::CPMC_IDX_SRC: decode = 3'h4;
        cpmc_pkg::CPMC_IDX_UPD: decode = 3'h5;
        default: decode = 3'h7;
      endcase
    end
  endfunction : decode

  // Returns the reset value of a slot.
  function automatic logic [7:0] rstval(input int i);
    case (i)
      0: rstval = cpmc_pkg::CPMC_RST_PWR;
      1: rstval = cpmc_pkg::CPMC_RST_CAL;
      2: rstval = cpmc_pkg::CPMC_RST_REF;
      3: rstval = cpmc_pkg::CPMC_RST_DIV;
      default: rstval = cpmc_pkg::CPMC_RST_SRC;
    endcase
  endfunction : rstval

  // -----------------------------------------------------------------
  // Write channel.
  // -----------------------------------------------------------------

  // Address and data are taken in either order and held until the response.
  assign AWREADY = !aw_have_q && !bvalid_q;
  assign WREADY = !w_have_q && !bvalid_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx = decode(aw_q);
  assign wr_hit = wr_idx != 3'h7;
  assign upd = wr_go && wr_idx == 3'h5 && w_q[0] && wstrb_q;

  // Captures the write address and data beats.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h00000000;
      wstrb_q <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_q <= 1'b1;
        aw_q <= AWADDR;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_q <= 1'b1;
        w_q <= WDATA;
        wstrb_q <= WSTRB[0];
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Issues the write response; unmapped addresses answer SLVERR.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_q <= 1'b0;
      bresp_q <= 1'b0;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= !wr_hit;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP = {bresp_q, 1'b0};

  // -----------------------------------------------------------------
  // Restore pin synchroniser.
  // -----------------------------------------------------------------

  // Three flops; the level moves only when the second and third agree.
  // The saved word must stay steady while the restore level is high.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      restore_s1_q <= 1'b0;
      restore_s2_q <= 1'b0;
      restore_s3_q <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      restore_s1_q <= RESTORE;
      restore_s2_q <= restore_s1_q;
      restore_s3_q <= restore_s2_q;
      if (restore_s2_q == restore_s3_q) begin
        restore_q <= restore_s3_q;
      end
    end
  end

  // -----------------------------------------------------------------
  // Staged and active registers.
  // -----------------------------------------------------------------

  // Staging takes writes; active copies staging on update; restore loads both from the saved word.
  generate
    for (genvar i = 0; i < 5; i++) begin : g_reg
      always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          stg_q[i] <= rstval(i);
          act_q[i] <= rstval(i);
        end else if (restore_q) begin
          stg_q[i] <= RESTORE_CFG[8*i +: 8];
          act_q[i] <= RESTORE_CFG[8*i +: 8];
        end else begin
          if (wr_go && wr_idx == 3'(i) && wstrb_q) begin
            stg_q[i] <= w_q[7:0];
          end
          if (upd) begin
            act_q[i] <= stg_q[i];
          end
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Calibration start.
  // -----------------------------------------------------------------

  // A rising commit of the calibrate bit starts a calibration pulse.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cal_prev_q <= 1'b0;
      cal_cnt_q <= 4'h0;
    end else begin
      cal_prev_q <= act_q[1][0];
      if (act_q[1][0] && !cal_prev_q) begin
        cal_cnt_q <= cpmc_pkg::CPMC_CAL_CYC;
      end else if (cal_cnt_q != 4'h0) begin
        cal_cnt_q <= cal_cnt_q - 4'h1;
      end
    end
  end

  assign CAL_START = act_q[1][0] && !cal_prev_q;
  assign CAL_BUSY = cal_cnt_q != 4'h0;

  // -----------------------------------------------------------------
  // Clock path outputs.
  // -----------------------------------------------------------------

  // Power field: 00 runs, any other code holds the PLL down.
  assign PLL_PWR_DOWN = act_q[0][1:0] != cpmc_pkg::CPMC_PWR_RUN;
  assign SRC_VCO = act_q[4][cpmc_pkg::CPMC_SEL_BIT];
  assign DIV_BYPASS = act_q[4][cpmc_pkg::CPMC_BYP_BIT];
  assign POL_NEG = act_q[0][cpmc_pkg::CPMC_POL_BIT];
  assign REF_EN = act_q[2][2:0];
  // VCO is only powered while the PLL runs on the internal source.
  assign VCO_PWR_ON = !PLL_PWR_DOWN && SRC_VCO;

  // Ratio 000 means 2, 001..110 give 1..6, 111 falls back to 2.
  always_comb begin
    unique case (act_q[3][2:0])
      3'h0: DIV_RATIO = 3'h2;
      3'h7: DIV_RATIO = 3'h2;
      default: DIV_RATIO = act_q[3][2:0];
    endcase
  end

  // -----------------------------------------------------------------
  // Read channel.
  // -----------------------------------------------------------------

  assign ARREADY = !rvalid_q;
  assign rd_go = ARVALID && !rvalid_q;
  assign rd_idx = decode(ARADDR);
  assign rd_hit = rd_idx != 3'h7;

  // Reads return staged values; the update register reads as zero.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 1'b0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= !rd_hit;
      rdata_q <= (rd_idx < 3'h5) ? {24'h000000, stg_q[rd_idx]} : 32'h00000000;
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = {rresp_q, 1'b0};

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------

  pwr_down_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PLL_PWR_DOWN == (act_q[0][1:0] != 2'h0)) else $error("PLL power mismatch.");
  src_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd |=> SRC_VCO == $past(stg_q[4][1])) else $error("Source select not committed.");
  bypass_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd |=> DIV_BYPASS == $past(stg_q[4][0])) else $error("Bypass not committed.");
  div_zero_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    act_q[3][2:0] == 3'h0 |-> DIV_RATIO == 3'h2) else $error("Divider default wrong.");
  pol_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd |=> POL_NEG == $past(stg_q[0][7])) else $error("Polarity not committed.");
  cal_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd && stg_q[1][0] && !act_q[1][0] |=> CAL_START ##1 CAL_BUSY[*7]) else $error("Calibration not started.");
  vco_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !SRC_VCO |-> !VCO_PWR_ON) else $error("VCO powered on external source.");
  stage_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !upd && !restore_q |=> $stable(act_q[4])) else $error("Active changed without update.");
  div_commit_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd && !restore_q |=> act_q[3] == $past(stg_q[3])) else $error("Divider not committed.");
  restore_load_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    restore_q |=> act_q[4] == $past(RESTORE_CFG[39:32])) else $error("Saved setup not restored.");
  reset_val_a: assert property (@(posedge REF_CLK)
    $rose(RST_B) |-> PLL_PWR_DOWN && !SRC_VCO && !DIV_BYPASS) else $error("Reset defaults wrong.");

  upd_c: cover property (@(posedge REF_CLK) disable iff (!RST_B) upd);
  cal_c: cover property (@(posedge REF_CLK) disable iff (!RST_B) CAL_START);
  vco_c: cover property (@(posedge REF_CLK) disable iff (!RST_B) VCO_PWR_ON);
  restore_c: cover property (@(posedge REF_CLK) disable iff (!RST_B) restore_q);
  slverr_c: cover property (@(posedge REF_CLK) disable iff (!RST_B) BVALID && BRESP == 2'h2);

endmodule : cpmc_top

// >>> core/cpmc_pkg.sv
// Functional notes
// - Power field: 00 locked run, 01 powered down.
// - Source bit 1 selects VCO, 0 external clock.
// - Bypass bit 0 uses divider, 1 skips it.
// - Polarity bit 0 positive, 1 negative.
// - Calibrate bit plus update strobe starts calibration.
// - Reset: PLL down, divider 000, divider used, external.
// - PLL on with external source keeps VCO off.
// - Reference enables drive inputs; restore saved setup.
package cpmc_pkg;

  // -----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // -----------------------------------------------------------------
  localparam logic [11:0] CPMC_IDX_PWR = 12'h010;
  localparam logic [11:0] CPMC_IDX_CAL = 12'h018;
  localparam logic [11:0] CPMC_IDX_REF = 12'h01C;
  localparam logic [11:0] CPMC_IDX_DIV = 12'h1E0;
  localparam logic [11:0] CPMC_IDX_SRC = 12'h1E1;
  localparam logic [11:0] CPMC_IDX_UPD = 12'h232;

  // -----------------------------------------------------------------
  // Field positions and values.
  // -----------------------------------------------------------------
  localparam int CPMC_POL_BIT = 7;
  localparam int CPMC_BYP_BIT = 0;
  localparam int CPMC_SEL_BIT = 1;
  localparam logic [1:0] CPMC_PWR_RUN = 2'h0;
  localparam logic [1:0] CPMC_PWR_DOWN = 2'h1;

  // -----------------------------------------------------------------
  // Reset values.
  // -----------------------------------------------------------------
  localparam logic [7:0] CPMC_RST_PWR = 8'h01;
  localparam logic [7:0] CPMC_RST_CAL = 8'h00;
  localparam logic [7:0] CPMC_RST_REF = 8'h00;
  localparam logic [7:0] CPMC_RST_DIV = 8'h00;
  localparam logic [7:0] CPMC_RST_SRC = 8'h00;

  // -----------------------------------------------------------------
  // Calibration pulse length in cycles.
  // -----------------------------------------------------------------
  localparam logic [3:0] CPMC_CAL_CYC = 4'h8;

endpackage : cpmc_pkg

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // ---------------------------------------------------------------
  // Signals.
  // ---------------------------------------------------------------
  logic REF_CLK, RST_B, RESTORE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic PLL_PWR_DOWN, VCO_PWR_ON, SRC_VCO, DIV_BYPASS, POL_NEG, CAL_START, CAL_BUSY;
  logic [39:0] RESTORE_CFG;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rdat;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, resp;
  logic [2:0] DIV_RATIO, REF_EN;
  int mismatches = 0;
  int checks_done = 0;
  int starts = 0;
  int busy_cyc = 0;

  cpmc_top u_cpmc_top (.REF_CLK(REF_CLK), .RST_B(RST_B), .RESTORE(RESTORE), .RESTORE_CFG(RESTORE_CFG),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .PLL_PWR_DOWN(PLL_PWR_DOWN), .VCO_PWR_ON(VCO_PWR_ON), .SRC_VCO(SRC_VCO), .DIV_BYPASS(DIV_BYPASS),
    .DIV_RATIO(DIV_RATIO), .POL_NEG(POL_NEG), .REF_EN(REF_EN), .CAL_START(CAL_START), .CAL_BUSY(CAL_BUSY));

  // Free-running 250 MHz clock.
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  // Counts calibration start pulses and busy cycles.
  always @(posedge REF_CLK) begin
    if (CAL_START === 1'b1) starts <= starts + 1;
    if (CAL_BUSY === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  // ---------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Write one register by index; address and data are offered together.
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    bit aw;
    bit w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    @(posedge REF_CLK);
    AWADDR <= {idx[9:0], 2'h0};
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(aw && w) && n++ < 50) begin
      @(posedge REF_CLK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    while (BVALID !== 1'b1 && n++ < 100) @(posedge REF_CLK);
    chk("bresp", BRESP, er);
  endtask : wr

  // Read one register by index.
  task automatic rd(input logic [11:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge REF_CLK);
    ARADDR <= {idx[9:0], 2'h0};
    ARVALID <= 1'b1;
    do @(posedge REF_CLK); while (ARREADY !== 1'b1 && ++n < 50);
    ARVALID <= 1'b0;
    while (RVALID !== 1'b1 && n++ < 100) @(posedge REF_CLK);
    chk("rresp", RRESP, er);
    chk("rdata", RDATA, {24'h0, exp});
  endtask : rd

  // Strobe the update bit and let the active copies settle.
  task automatic commit();
    wr(cpmc_pkg::CPMC_IDX_UPD, 8'h01);
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask : commit

  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  task automatic t_reset();
    @(posedge REF_CLK);
    #1;
    chk("pwr_down", PLL_PWR_DOWN, 1);
    chk("src_vco", SRC_VCO, 0);
    chk("bypass", DIV_BYPASS, 0);
    chk("ratio", DIV_RATIO, 2);
    rd(cpmc_pkg::CPMC_IDX_PWR, cpmc_pkg::CPMC_RST_PWR);
    rd(cpmc_pkg::CPMC_IDX_DIV, cpmc_pkg::CPMC_RST_DIV);
    rd(cpmc_pkg::CPMC_IDX_SRC, cpmc_pkg::CPMC_RST_SRC);
  endtask : t_reset

  task automatic t_stage();
    wr(cpmc_pkg::CPMC_IDX_PWR, 8'h80);
    #1;
    chk("pwr_staged", PLL_PWR_DOWN, 1);
    chk("pol_staged", POL_NEG, 0);
    commit();
    chk("pwr_run", PLL_PWR_DOWN, 0);
    chk("pol_neg", POL_NEG, 1);
    chk("vco_off", VCO_PWR_ON, 0);
    rd(cpmc_pkg::CPMC_IDX_PWR, 8'h80);
    wr(cpmc_pkg::CPMC_IDX_PWR, 8'h01);
    commit();
    chk("pwr_down", PLL_PWR_DOWN, 1);
    chk("pol_pos", POL_NEG, 0);
    wr(cpmc_pkg::CPMC_IDX_PWR, 8'h00);
  endtask : t_stage

  task automatic t_route();
    for (int i = 0; i < 4; i++) begin
      wr(cpmc_pkg::CPMC_IDX_SRC, 8'(i));
      commit();
      chk("src_vco", SRC_VCO, i / 2);
      chk("bypass", DIV_BYPASS, i % 2);
      chk("vco_pwr", VCO_PWR_ON, i / 2);
    end
  endtask : t_route

  task automatic t_div();
    for (int i = 0; i < 8; i++) begin
      wr(cpmc_pkg::CPMC_IDX_DIV, 8'(i));
      wr(cpmc_pkg::CPMC_IDX_REF, 8'(i));
      commit();
      chk("ratio", DIV_RATIO, (i == 0 || i == 7) ? 2 : i);
      chk("ref_en", REF_EN, i);
    end
  endtask : t_div

  task automatic t_cal();
    int s0;
    int b0;
    s0 = starts;
    b0 = busy_cyc;
    wr(cpmc_pkg::CPMC_IDX_CAL, 8'h01);
    repeat (3) @(posedge REF_CLK);
    chk("cal_staged", starts, s0);
    commit();
    repeat (12) @(posedge REF_CLK);
    chk("cal_start", starts, s0 + 1);
    chk("cal_busy", busy_cyc, b0 + cpmc_pkg::CPMC_CAL_CYC);
    commit();
    chk("cal_again", starts, s0 + 1);
    wr(cpmc_pkg::CPMC_IDX_CAL, 8'h00);
    commit();
    wr(cpmc_pkg::CPMC_IDX_CAL, 8'h01);
    commit();
    repeat (12) @(posedge REF_CLK);
    chk("cal_restart", starts, s0 + 2);
  endtask : t_cal

  task automatic t_bus();
    wr(12'h0FF, 8'h5A, 2'h2);
    rd(12'h0FF, 8'h00, 2'h2);
    rd(cpmc_pkg::CPMC_IDX_UPD, 8'h00);
  endtask : t_bus

  task automatic t_restore();
    @(posedge REF_CLK);
    RESTORE <= 1'b1;
    RESTORE_CFG <= 40'h02_04_03_00_80;
    repeat (4) @(posedge REF_CLK);
    RESTORE <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    #1;
    chk("rst_src", SRC_VCO, 1);
    chk("rst_ratio", DIV_RATIO, 4);
    chk("rst_ref", REF_EN, 3);
    chk("rst_pol", POL_NEG, 1);
    chk("rst_vco", VCO_PWR_ON, 1);
  endtask : t_restore

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------
  initial begin
    RST_B = 1'b0;
    RESTORE = 1'b0;
    RESTORE_CFG = 40'h0;
    {AWVALID, WVALID, ARVALID} = 3'h0;
    {AWADDR, ARADDR} = 24'h0;
    WDATA = 32'h0;
    WSTRB = 4'hF;
    BREADY = 1'b1;
    RREADY = 1'b1;
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1'b1;
    t_reset();
    t_stage();
    t_route();
    t_div();
    t_cal();
    t_bus();
    t_restore();
    results();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge REF_CLK);
    mismatches++;
    results();
  end
endmodule : tb_top
